// file: src/strobed_handshake_io_host.sv
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "hs_host_params.svh"

// Summary of operation
// - Strobed ports borrow port C lines; peripheral strobes, device drives flags.
// - Peripheral pulls load_strobe_n low; device latches data on that level.
// - Output data valid only at output_full_n rising edge; peripheral latches then.
// - Any order allowed if write precedes accept and strobe precedes read.

module strobed_handshake_io_host import hs_host_pkg::*; (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Device bus pins
    output logic DEV_CS_N,
    output logic DEV_RD_N,
    output logic DEV_WR_N,
    output logic [1:0] DEV_A,
    input wire logic [7:0] DEV_D_I,
    output logic [7:0] DEV_D_O,
    output logic DEV_D_OE,
    output logic DEV_RESET,
    // Service request pins from the device
    input wire logic GRPA_SREQ,
    input wire logic GRPB_SREQ
);

    logic [1:0] rst_sync_ff;
    byte_t d_meta_ff, d_sync_ff;
    logic [1:0] sreq_meta_ff, sreq_sync_ff;
    logic pready_ff, pslverr_ff, dev_reset_ff, done_flag_ff;
    logic [31:0] prdata_ff, cmd_ff;
    logic [2:0] en_ff;
    logic seq_busy, seq_done;
    byte_t seq_rbyte;

    wire rst_n = rst_sync_ff[1];

    // Bytes sent for a command; a bit command is rebuilt in its fixed form
    function automatic byte_t dev_byte(input logic [31:0] w);
        if (w[`HS_CMD_BITOP_BIT]) begin
            return {4'h0, w[3:1], w[0]};
        end
        return w[7:0];
    endfunction : dev_byte

    // Device address for a command; bit commands always go to control
    function automatic logic [1:0] dev_addr(input logic [31:0] w);
        if (w[`HS_CMD_BITOP_BIT]) begin
            return `HS_DEV_CTRL;
        end
        return w[`HS_CMD_ADDR_LSB +: 2];
    endfunction : dev_addr

    // Reset release through two flops
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    // Pin inputs pass two flops; request lines are port C bits 3 and 0
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            d_meta_ff <= 8'h00;
            d_sync_ff <= 8'h00;
            sreq_meta_ff <= 2'b00;
            sreq_sync_ff <= 2'b00;
        end else begin
            d_meta_ff <= DEV_D_I;
            d_sync_ff <= d_meta_ff;
            sreq_meta_ff <= {GRPA_SREQ, GRPB_SREQ};
            sreq_sync_ff <= sreq_meta_ff;
        end
    end

    // APB decode; access runs two cycles, commit on the ready edge
    wire apb_first = PSEL && PENABLE && !pready_ff;
    wire apb_commit = PSEL && PENABLE && pready_ff;
    wire hit_cmd = (PADDR == `HS_OFF_CMD);
    wire hit_status = (PADDR == `HS_OFF_STATUS);
    wire hit_ctrl = (PADDR == `HS_OFF_CTRL);
    wire mapped = hit_cmd || hit_status || hit_ctrl;
    wire refuse = PWRITE && hit_cmd && seq_busy; // One command in flight
    wire cmd_go = apb_commit && PWRITE && hit_cmd && !pslverr_ff;
    wire ctrl_wr = apb_commit && PWRITE && hit_ctrl;
    wire reset_req = ctrl_wr && PWDATA[`HS_CTRL_RESET_BIT];

    // Decode of the command that just finished on the device bus
    wire [31:0] cur_cmd = cmd_ff;
    wire byte_t cur_byte = dev_byte(cur_cmd);
    // A bit command is always a control write, whatever its read bit says
    wire cur_is_ctrl = (cur_cmd[`HS_CMD_BITOP_BIT] || !cur_cmd[`HS_CMD_RD_BIT]) &&
                       (dev_addr(cur_cmd) == `HS_DEV_CTRL);
    wire mode_done = seq_done && cur_is_ctrl && cur_byte[`HS_CW_MODE_BIT];
    wire bit_done = seq_done && cur_is_ctrl && !cur_byte[`HS_CW_MODE_BIT];
    wire [2:0] bit_idx = cur_byte[3:1];

    // Shadow of the request enables as last programmed
    wire [2:0] en_hit = {bit_idx == `HS_EN_POS_A_OUT,
                         bit_idx == `HS_EN_POS_A_IN,
                         bit_idx == `HS_EN_POS_B} & {3{bit_done}};
    wire en_clear = mode_done || reset_req;
    wire [2:0] en_base = en_clear ? 3'b000 : en_ff;
    wire [2:0] nxt_en = (en_base & ~en_hit) | (en_hit & {3{cur_byte[0]}});

    // Read mux; status carries live request pins and last read byte
    wire [31:0] status_word = {16'h0000, seq_rbyte, 1'b0, en_ff, sreq_sync_ff,
                               done_flag_ff, seq_busy};
    wire [31:0] rd_mux = hit_cmd ? cmd_ff :
                         hit_status ? status_word :
                         hit_ctrl ? {31'h0000_0000, dev_reset_ff} : 32'h0000_0000;

    // APB answer, one wait state
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= apb_first;
            pslverr_ff <= apb_first && (!mapped || refuse);
            prdata_ff <= (apb_first && !PWRITE) ? rd_mux : 32'h0000_0000;
        end
    end

    // Software state; the sequencer is idle whenever a command lands
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ff <= `HS_CMD_RST;
            dev_reset_ff <= `HS_CTRL_RST;
            done_flag_ff <= 1'b0;
            en_ff <= 3'b000;
        end else begin
            if (cmd_go) begin
                cmd_ff <= PWDATA;
            end
            if (ctrl_wr) begin
                dev_reset_ff <= PWDATA[`HS_CTRL_RESET_BIT];
            end
            done_flag_ff <= seq_done || (done_flag_ff && !cmd_go);
            en_ff <= nxt_en;
        end
    end

    // Port writes are issued in software order, with no wait on any peer accept
    hs_bus_cycle u_cycle (
        .clk(CLK),
        .rst_n(rst_n),
        .start(cmd_go),
        .rd(PWDATA[`HS_CMD_RD_BIT] && !PWDATA[`HS_CMD_BITOP_BIT]),
        .addr(dev_addr(PWDATA)),
        .wbyte(dev_byte(PWDATA)),
        .d_in(d_sync_ff),
        .cs_n(DEV_CS_N),
        .rd_n(DEV_RD_N),
        .wr_n(DEV_WR_N),
        .a(DEV_A),
        .d_o(DEV_D_O),
        .d_oe(DEV_D_OE),
        .busy(seq_busy),
        .done(seq_done),
        .rbyte(seq_rbyte)
    );

    assign PRDATA = prdata_ff;
    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign DEV_RESET = dev_reset_ff;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    property p_pready_pulse;
        PREADY |=> !PREADY;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("ready held two cycles");

    property p_refuse_busy;
        apb_first && PWRITE && hit_cmd && seq_busy |=> PREADY && PSLVERR && !cmd_go
            ##1 $stable(cmd_ff);
    endproperty
    a_refuse_busy: assert property (p_refuse_busy) else $error("busy command not refused");

    property p_bitop_form;
        !DEV_WR_N && cmd_ff[`HS_CMD_BITOP_BIT] |-> DEV_A == `HS_DEV_CTRL && !DEV_D_O[7];
    endproperty
    a_bitop_form: assert property (p_bitop_form) else $error("bit command malformed");

    property p_mode_clears_en;
        mode_done |=> en_ff == 3'b000;
    endproperty
    a_mode_clears_en: assert property (p_mode_clears_en) else $error("enables not cleared");

    c_refused: cover property (PREADY && PSLVERR && hit_cmd);
    c_bit_enable: cover property (bit_done && bit_idx == `HS_EN_POS_A_IN ##1 en_ff[1]);
    c_reset_dev: cover property ($rose(DEV_RESET));

endmodule : strobed_handshake_io_host

// file: src/hs_host_params.svh
`ifndef HS_HOST_PARAMS_SVH
`define HS_HOST_PARAMS_SVH

// Clock rate and ns-to-cycles rounding up
`define HS_CLK_MHZ 100
`define HS_CYC_UP(ns) ((((ns) * `HS_CLK_MHZ) + 999) / 1000)

// Device bus timing, in ns
`define HS_T_RD_NS 150
`define HS_T_WR_NS 100
`define HS_T_WD_NS 30
`define HS_T_RV_NS 300

// Device bus timing, in cycles
`define HS_RD_CYC `HS_CYC_UP(`HS_T_RD_NS)
`define HS_WR_CYC `HS_CYC_UP(`HS_T_WR_NS)
`define HS_HOLD_CYC `HS_CYC_UP(`HS_T_WD_NS)
`define HS_REC_CYC `HS_CYC_UP(`HS_T_RV_NS)

// APB register offsets
`define HS_OFF_CMD 8'h00
`define HS_OFF_STATUS 8'h04
`define HS_OFF_CTRL 8'h08

// Command word fields
`define HS_CMD_ADDR_LSB 8
`define HS_CMD_RD_BIT 10
`define HS_CMD_BITOP_BIT 11
`define HS_CMD_RST 32'h0000_0000

// Control register fields
`define HS_CTRL_RESET_BIT 0
`define HS_CTRL_RST 1'b0

// Device addresses and control word fields
`define HS_DEV_PORTC 2'h2
`define HS_DEV_CTRL 2'h3
`define HS_CW_MODE_BIT 7

// Port C positions of the request enables
`define HS_EN_POS_B 3'h2
`define HS_EN_POS_A_IN 3'h4
`define HS_EN_POS_A_OUT 3'h6

`endif

// file: src/hs_host_pkg.sv
package hs_host_pkg;

    // Device bus cycle sequencer, Gray along the path except S_RECOVER to S_IDLE
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_SETUP = 3'b001,
        S_STROBE = 3'b011,
        S_HOLD = 3'b010,
        S_RECOVER = 3'b110
    } seq_state_t;

    typedef logic [7:0] byte_t;

endpackage : hs_host_pkg

// file: src/hs_bus_cycle.sv
`timescale 1ns/10ps
`include "hs_host_params.svh"

module hs_bus_cycle import hs_host_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request
    input wire logic start,
    input wire logic rd,
    input wire logic [1:0] addr,
    input wire byte_t wbyte,
    input wire byte_t d_in,
    // Device pins
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [1:0] a,
    output byte_t d_o,
    output logic d_oe,
    // Answer
    output logic busy,
    output logic done,
    output byte_t rbyte
);

    localparam int RD_CYC = `HS_RD_CYC;
    localparam int WR_CYC = `HS_WR_CYC;
    localparam int HOLD_CYC = `HS_HOLD_CYC;
    localparam int REC_CYC = `HS_REC_CYC;

    seq_state_t state_ff;
    logic [5:0] cnt_ff;
    logic rd_op_ff;
    logic cs_n_ff, rd_n_ff, wr_n_ff, d_oe_ff, done_ff;
    logic [1:0] a_ff;
    byte_t d_o_ff, rbyte_ff;

    // Strobe length depends on direction
    wire [5:0] strobe_last = rd_op_ff ? 6'(RD_CYC - 1) : 6'(WR_CYC - 1);
    wire [5:0] hold_last = 6'(HOLD_CYC - 1);
    wire [5:0] rec_last = 6'(REC_CYC - 1);

    assign cs_n = cs_n_ff;
    assign rd_n = rd_n_ff;
    assign wr_n = wr_n_ff;
    assign a = a_ff;
    assign d_o = d_o_ff;
    assign d_oe = d_oe_ff;
    assign done = done_ff;
    assign rbyte = rbyte_ff;
    assign busy = (state_ff != S_IDLE);

    // One device read or write cycle; address and data wrap the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= S_IDLE;
            cnt_ff <= 6'h00;
            rd_op_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
            a_ff <= 2'h0;
            d_o_ff <= 8'h00;
            d_oe_ff <= 1'b0;
            done_ff <= 1'b0;
            rbyte_ff <= 8'h00;
        end else begin
            done_ff <= 1'b0;
            cnt_ff <= cnt_ff + 6'h01;
            unique case (state_ff)
                S_IDLE: begin
                    cnt_ff <= 6'h00;
                    if (start) begin
                        cs_n_ff <= 1'b0;
                        a_ff <= addr;
                        rd_op_ff <= rd;
                        d_o_ff <= wbyte;
                        d_oe_ff <= !rd; // Never drive the bus during a read
                        state_ff <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    rd_n_ff <= !rd_op_ff;
                    wr_n_ff <= rd_op_ff;
                    cnt_ff <= 6'h00;
                    state_ff <= S_STROBE;
                end
                S_STROBE: begin
                    if (cnt_ff == strobe_last) begin
                        rd_n_ff <= 1'b1;
                        wr_n_ff <= 1'b1;
                        // Synced data lags the pin by two cycles, still past access time
                        if (rd_op_ff) begin
                            rbyte_ff <= d_in;
                        end
                        cnt_ff <= 6'h00;
                        state_ff <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    // Data and address held past the write's rising edge
                    if (cnt_ff == hold_last) begin
                        cs_n_ff <= 1'b1;
                        d_oe_ff <= 1'b0;
                        cnt_ff <= 6'h00;
                        state_ff <= S_RECOVER;
                    end
                end
                S_RECOVER: begin
                    // Recovery keeps back-to-back cycles legal for the device
                    if (cnt_ff == rec_last) begin
                        done_ff <= 1'b1;
                        state_ff <= S_IDLE;
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_no_both_strobes;
        !(!rd_n && !wr_n);
    endproperty
    a_no_both_strobes: assert property (p_no_both_strobes) else $error("read and write both low");

    property p_rd_width;
        $rose(rd_n) |-> !$past(rd_n, RD_CYC) && $past(rd_n, RD_CYC + 1);
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("read strobe width wrong");

    property p_wr_width;
        $rose(wr_n) |-> !$past(wr_n, WR_CYC) && $past(wr_n, WR_CYC + 1);
    endproperty
    a_wr_width: assert property (p_wr_width) else $error("write strobe width wrong");

    property p_wr_data_hold;
        $rose(wr_n) |-> (d_oe && !cs_n && $stable(d_o)) [*3];
    endproperty
    a_wr_data_hold: assert property (p_wr_data_hold) else $error("write data not held");

    property p_no_drive_on_read;
        !rd_n |-> !d_oe;
    endproperty
    a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("bus driven in read");

    property p_addr_stable;
        !cs_n && !$past(cs_n) |-> $stable(a);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved in cycle");

    property p_start_done;
        start && !busy |=> !cs_n ##[40:60] done;
    endproperty
    a_start_done: assert property (p_start_done) else $error("cycle did not finish in time");

    c_read_cycle: cover property (start && !busy && rd ##[1:80] done);
    c_write_cycle: cover property (start && !busy && !rd ##[1:80] done);

endmodule : hs_bus_cycle

// file: sim/hs_dev_model.sv
`timescale 1ns/10ps

// Device model: group A strobed input, group B strobed output
module hs_dev_model (
    // Host side pins
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic reset,
    input wire logic [1:0] a,
    input wire logic [7:0] host_d,
    input wire logic host_oe,
    // Peripheral side
    input wire logic stb_a_n,
    input wire logic ack_b_n,
    // Port A is input only here, its drivers stay off
    input wire logic [7:0] pa_pins,
    // Resolved bus and requests
    output logic [7:0] bus,
    output logic sreq_a,
    output logic sreq_b
);
    logic [7:0] cw = 8'h9b;
    logic [7:0] pc = 8'h00;
    logic [7:0] la = 8'h00;
    logic [7:0] rv;
    logic [7:0] pcrd;
    logic [7:0] wmask;
    logic en2 = 1'b0;
    logic en4 = 1'b0;
    logic full_a = 1'b0;
    logic obf_b_n = 1'b1;
    // Only group A has a strobed decode beyond group B's single mode bit
    wire logic gma = cw[6:5] == 2'h1;
    wire logic rdc = !cs_n && !rd_n;

    // Output request waits until the peer has taken the byte
    assign sreq_b = cw[2] && !cw[1] && en2 && obf_b_n && ack_b_n &&
                    !(!cs_n && !wr_n && a == 2'h1);
    assign sreq_a = gma && full_a && en4 && stb_a_n && !(rdc && a == 2'h0);
    // Enable flags replace strobe and accept states on a read
    assign pcrd = {pc[7:6], gma ? {full_a, en4, sreq_a} : pc[5:3],
                   cw[2] ? {en2, cw[1] ? 1'b0 : obf_b_n, sreq_b} : pc[2:0]};
    assign wmask = {(cw[6:5] == 2'h0 && !cw[3]) ? 4'hf : 4'h0,
                    (!cw[2] && !cw[0]) ? (gma ? 4'h7 : 4'hf) : 4'h0};
    assign rv = a == 2'h0 ? la : a == 2'h2 ? pcrd : a == 2'h3 ? cw : pa_pins;
    // Released bus shows the inverse, so a stale capture cannot match
    assign bus = host_oe ? host_d : rdc ? rv : ~rv;

    // Strobe low loads the latch and raises full
    always @(negedge stb_a_n) if (gma) begin
        la = pa_pins;
        full_a = 1'b1;
    end

    // Read of port A ends the full state
    always @(posedge rd_n) if (!cs_n && a == 2'h0) full_a = 1'b0;

    // Peer accept ends the output-full state
    always @(negedge ack_b_n) obf_b_n = 1'b1;

    // Writes act on the write strobe rising edge; no sampling delay here
    always @(posedge wr_n or posedge reset) begin
        if (reset) begin
            cw = 8'h9b;
            {en2, en4} = 2'b00;
            obf_b_n = 1'b1;
        end else if (!cs_n && a == 2'h1) begin
            if (cw[2] && !cw[1]) obf_b_n = 1'b0;
        end else if (!cs_n && a == 2'h2) begin
            pc = (pc & ~wmask) | (host_d & wmask);
        end else if (!cs_n && a == 2'h3 && host_d[7]) begin
            cw = host_d;
            pc = 8'h00;
            full_a = 1'b0;
            obf_b_n = 1'b1;
            {en2, en4} = 2'b00;
        end else if (!cs_n && a == 2'h3) begin
            if (gma && host_d[3:1] == 3'h4) en4 = host_d[0];
            else if (cw[2] && host_d[3:1] == 3'h2) en2 = host_d[0];
            else pc[host_d[3:1]] = host_d[0];
        end
    end
endmodule : hs_dev_model

// file: sim/strobed_handshake_io_host_tb.sv
`timescale 1ns/10ps
`include "hs_host_params.svh"

module strobed_handshake_io_host_tb import hs_host_pkg::*;;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic stb_n = 1'b1;
    logic ack_n = 1'b1;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, cs_n, rd_n, wr_n, oe, dres, sa, sb;
    wire logic [1:0] da;
    wire byte_t dout, din;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] r;
    logic e;
    // Device command and expected byte, checked on reads only
    logic [19:0] rows [16] = '{20'h7009b, 20'h38000, 20'h2a500, 20'h600a5, 20'h80000,
        20'h600a4, 20'h3b400, 20'h60002, 20'h2ff00, 20'h60002, 20'h80f00, 20'h60082,
        20'h80900, 20'h60092, 20'h80500, 20'h60097};

    always #5 clk = ~clk;

    strobed_handshake_io_host dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .DEV_CS_N(cs_n), .DEV_RD_N(rd_n), .DEV_WR_N(wr_n), .DEV_A(da),
        .DEV_D_I(din), .DEV_D_O(dout), .DEV_D_OE(oe), .DEV_RESET(dres), .GRPA_SREQ(sa),
        .GRPB_SREQ(sb));

    hs_dev_model dev_m (.cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .reset(dres), .a(da),
        .host_d(dout), .host_oe(oe), .stb_a_n(stb_n), .pa_pins(8'h3c), .bus(din),
        .ack_b_n(ack_n), .sreq_a(sa), .sreq_b(sb));

    // Hang guard, generous for the 23 device cycles of the run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One transfer; held until pready is seen high at an edge
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wait_done;
        do apb(1'b0, `HS_OFF_STATUS, 32'h0); while (r[1:0] !== 2'b10);
    endtask : wait_done

    task dev(input logic [11:0] c);
        apb(1'b1, `HS_OFF_CMD, {20'h0, c});
        wait_done();
    endtask : dev

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b1, `HS_OFF_CTRL, 32'h1);
        apb(1'b1, `HS_OFF_CTRL, 32'h0);
        foreach (rows[i]) begin
            dev(rows[i][19:8]);
            if (rows[i][18]) check("device byte", r[15:8], rows[i][7:0]);
        end
        check("enable shadow", r[6:4], 3'b011);
        check("service requests", r[3:2], 2'b01);
        $display("table test done");
        @(posedge clk);
        stb_n <= 1'b0;
        repeat (3) @(posedge clk);
        stb_n <= 1'b1;
        repeat (5) @(posedge clk);
        apb(1'b0, `HS_OFF_STATUS, 32'h0);
        check("request a", r[3], 1'b1);
        dev(12'h600);
        check("port c status", r[15:8], 8'hbf);
        dev(12'h400);
        check("port a latch", r[15:8], 8'h3c);
        check("request a cleared", r[3], 1'b0);
        dev(12'h155);
        check("request b on write", r[2], 1'b0);
        ack_n <= 1'b0;
        repeat (3) @(posedge clk);
        ack_n <= 1'b1;
        repeat (5) @(posedge clk);
        apb(1'b0, `HS_OFF_STATUS, 32'h0);
        check("request b on accept", r[2], 1'b1);
        dev(12'h380);
        check("mode clears flags", r[6:2], 5'h0);
        $display("handshake test done");
        apb(1'b0, 8'h0c, 32'h0);
        check("unmapped error", e, 1'b1);
        check("unmapped data", r, 32'h0);
        apb(1'b1, `HS_OFF_CMD, 32'h809);
        apb(1'b1, `HS_OFF_CMD, 32'h600);
        check("busy refusal", e, 1'b1);
        apb(1'b0, `HS_OFF_CMD, 32'h0);
        check("command readback", r, 32'h809);
        wait_done();
        check("shadow bit four", r[6:4], 3'b010);
        dev(12'h80d);
        check("shadow bit six", r[6:4], 3'b110);
        apb(1'b1, `HS_OFF_STATUS, 32'hffff_ffff);
        check("status write", e, 1'b0);
        apb(1'b1, `HS_OFF_CTRL, 32'h1);
        apb(1'b0, `HS_OFF_STATUS, 32'h0);
        check("reset clears shadow", r[6:4], 3'b000);
        apb(1'b0, `HS_OFF_CTRL, 32'h0);
        check("control readback", r, 32'h1);
        apb(1'b1, `HS_OFF_CTRL, 32'h0);
        dev(12'h700);
        check("control word after reset", r[15:8], 8'h9b);
        $display("bus test done");
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        check("reset pins", {pready, pslverr, cs_n, rd_n, wr_n, oe, dres}, 7'h1c);
        check("reset read data", prdata, 32'h0);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, `HS_OFF_STATUS, 32'h0);
        check("status after reset", r, 32'h0);
        apb(1'b0, `HS_OFF_CMD, 32'h0);
        check("command after reset", r, 32'h0);
        $display("reset test done");
        tally_and_finish();
    end
endmodule : strobed_handshake_io_host_tb
